//--- common/ebl_pkg.sv
// Purpose: Shared constants for the encrypted stream loader
// Assumes: 128-bit stream words, 4-bit instruction register
// Notes:   Instruction codes and header layout are local choices
//
// How it works
// - Content key lives in protected storage and is never shifted out.
// - A 128-bit keyed decrypt stage turns each stream word into plaintext.
// - Words under a foreign key decrypt to garbage and fail the check.
// - Stream check covers every word and ends before any erase starts.
// - Decrypt and check run while the user logic keeps working.
// - A passing stream erases the targets, then programs the stored words.
// - A failing stream causes no erase, no load, no interruption.
// - While locked, array, ROM and security writes need the matching passkey.
// - Permanent option freezes security settings and content key for good.
// - Header selects array, user ROM and flash block, alone or together.
// - Programming runs over a standard test-access port state machine.
package ebl_pkg;
    localparam int        WORD_W     = 128;
    localparam int        IR_W       = 4;
    localparam int        TGT_W      = 3;
    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_KEY     = 4'h2;
    localparam logic [3:0] IR_PASS    = 4'h3;
    localparam logic [3:0] IR_UNLOCK  = 4'h4;
    localparam logic [3:0] IR_PERM    = 4'h5;
    localparam logic [3:0] IR_STREAM  = 4'h6;
    localparam logic [3:0] IR_END     = 4'h7;
    localparam logic [3:0] IR_STATUS  = 4'h8;
    localparam logic [3:0] IR_BYPASS  = 4'hf;
    // ************************************************************
    // Stream header layout and reset values
    // ************************************************************
    localparam int          TGT_LSB   = 0;
    localparam int          MAGIC_LSB = 112;
    localparam logic [15:0] MAGIC     = 16'ha5c3;
    localparam logic [0:0]  FLAG_RST  = 1'h0;
    localparam int          ST_W      = 8;
    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
        T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UPD_IR
    } ebl_tap_e;
    typedef enum logic [1:0] {L_IDLE, L_CHECK, L_ERASE, L_PROG} ebl_ld_e;
endpackage

//--- rtl/ebl_fifo.sv
// Purpose: Word FIFO between the port shifter and the decrypt stage
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty come from a pointer pair with a wrap bit
`timescale 1ns/1ps
module ebl_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output wire logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output wire logic             out_valid,
    input  wire logic             out_ready,
    output wire logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire              empty = (wr_q == rd_q);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

//--- rtl/ebl_loader.sv
// Purpose: Encrypted, authenticated in-system programming gate
// Assumes: Port pins are asynchronous and far slower than core_clk
// Notes:   Whole stream is held on chip so nothing commits before the check
`timescale 1ns/1ps
module ebl_loader #(
    parameter int W            = 128,
    parameter int STREAM_WORDS = 16,
    parameter int FIFO_DEPTH   = 16,
    parameter int PASS_W       = 32
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // Test-access port pins
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    output wire logic                     tdo,
    output wire logic                     tdo_oe,
    // Array programming side
    input  wire logic                     arr_ack,
    output wire logic                     erase_req,
    output wire logic [ebl_pkg::TGT_W-1:0] erase_target,
    output wire logic                     prog_valid,
    output wire logic [$clog2(STREAM_WORDS)-1:0] prog_addr,
    output wire logic [W-1:0]             prog_data,
    // Status
    output wire logic                     auth_pass,
    output wire logic                     auth_fail,
    output wire logic                     cfg_busy,
    output wire logic                     lock_active,
    output wire logic                     perm_active,
    output wire logic                     fifo_stall
);
    localparam int AW = $clog2(STREAM_WORDS);
    localparam int CW = $clog2(STREAM_WORDS + 1);
    // ************************************************************
    // Functions
    // ************************************************************
    function automatic ebl_pkg::ebl_tap_e tap_next(input ebl_pkg::ebl_tap_e s, input logic m);
        case (s)
            ebl_pkg::T_RESET:  tap_next = m ? ebl_pkg::T_RESET  : ebl_pkg::T_IDLE;
            ebl_pkg::T_IDLE:   tap_next = m ? ebl_pkg::T_SEL_DR : ebl_pkg::T_IDLE;
            ebl_pkg::T_SEL_DR: tap_next = m ? ebl_pkg::T_SEL_IR : ebl_pkg::T_CAP_DR;
            ebl_pkg::T_CAP_DR: tap_next = m ? ebl_pkg::T_EX1_DR : ebl_pkg::T_SH_DR;
            ebl_pkg::T_SH_DR:  tap_next = m ? ebl_pkg::T_EX1_DR : ebl_pkg::T_SH_DR;
            ebl_pkg::T_EX1_DR: tap_next = m ? ebl_pkg::T_UPD_DR : ebl_pkg::T_PA_DR;
            ebl_pkg::T_PA_DR:  tap_next = m ? ebl_pkg::T_EX2_DR : ebl_pkg::T_PA_DR;
            ebl_pkg::T_EX2_DR: tap_next = m ? ebl_pkg::T_UPD_DR : ebl_pkg::T_SH_DR;
            ebl_pkg::T_UPD_DR: tap_next = m ? ebl_pkg::T_SEL_DR : ebl_pkg::T_IDLE;
            ebl_pkg::T_SEL_IR: tap_next = m ? ebl_pkg::T_RESET  : ebl_pkg::T_CAP_IR;
            ebl_pkg::T_CAP_IR: tap_next = m ? ebl_pkg::T_EX1_IR : ebl_pkg::T_SH_IR;
            ebl_pkg::T_SH_IR:  tap_next = m ? ebl_pkg::T_EX1_IR : ebl_pkg::T_SH_IR;
            ebl_pkg::T_EX1_IR: tap_next = m ? ebl_pkg::T_UPD_IR : ebl_pkg::T_PA_IR;
            ebl_pkg::T_PA_IR:  tap_next = m ? ebl_pkg::T_EX2_IR : ebl_pkg::T_PA_IR;
            ebl_pkg::T_EX2_IR: tap_next = m ? ebl_pkg::T_UPD_IR : ebl_pkg::T_SH_IR;
            ebl_pkg::T_UPD_IR: tap_next = m ? ebl_pkg::T_SEL_DR : ebl_pkg::T_IDLE;
            default:           tap_next = ebl_pkg::T_RESET;
        endcase
    endfunction
    // Toy keystream; a real block cipher core slots in here
    function automatic logic [W-1:0] keystream(input logic [W-1:0] k, input logic [CW-1:0] i);
        keystream = k ^ {(W/8){8'(i)}};
    endfunction
    function automatic logic [W-1:0] mac_step(input logic [W-1:0] m, p, k);
        mac_step = {m[W-2:0], m[W-1]} ^ p ^ k;
    endfunction
    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic [2:0] tck_q;
    logic [1:0] tms_q;
    logic [1:0] tdi_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tck_q <= '0;
            tms_q <= '0;
            tdi_q <= '0;
        end else begin
            tck_q <= {tck_q[1:0], tck};
            tms_q <= {tms_q[0], tms};
            tdi_q <= {tdi_q[0], tdi};
        end
    end
    wire tck_rise = tck_q[1] && !tck_q[2];
    wire tck_fall = !tck_q[1] && tck_q[2];
    // ************************************************************
    // Test-access port
    // ************************************************************
    ebl_pkg::ebl_tap_e      tap_q;
    logic [ebl_pkg::IR_W-1:0] ir_sh_q;
    logic [ebl_pkg::IR_W-1:0] ir_q;
    logic [W-1:0]           dr_q;
    logic                   tdo_q;
    logic                   tdo_oe_q;
    logic [W-1:0]           key_q;
    logic [PASS_W-1:0]      pass_q;
    logic                   lock_q;
    logic                   unlk_q;
    logic                   perm_q;
    logic                   ok_q;
    logic                   fail_q;
    logic                   ovr_q;
    ebl_pkg::ebl_ld_e       ld_q;
    wire upd_dr  = tck_rise && (tap_q == ebl_pkg::T_UPD_DR);
    wire upd_ir  = tck_rise && (tap_q == ebl_pkg::T_UPD_IR);
    wire can_mod = !lock_q || unlk_q;
    wire can_sec = can_mod && !perm_q;
    // Key never enters the capture path, only verdict and flags do
    wire [ebl_pkg::ST_W-1:0] status = {2'h0, ovr_q, perm_q, lock_q, unlk_q, fail_q, ok_q};
    wire [W-1:0] cap_val = (ir_q == ebl_pkg::IR_STATUS) ? W'(status) : '0;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tap_q    <= ebl_pkg::T_RESET;
            ir_sh_q  <= '0;
            ir_q     <= ebl_pkg::IR_BYPASS;
            dr_q     <= '0;
            tdo_q    <= ebl_pkg::FLAG_RST;
            tdo_oe_q <= ebl_pkg::FLAG_RST;
        end else begin
            if (tck_rise) begin
                tap_q <= tap_next(tap_q, tms_q[1]);
                case (tap_q)
                    ebl_pkg::T_RESET:  ir_q    <= ebl_pkg::IR_BYPASS;
                    ebl_pkg::T_CAP_IR: ir_sh_q <= ebl_pkg::IR_CAPTURE;
                    ebl_pkg::T_SH_IR:  ir_sh_q <= {tdi_q[1], ir_sh_q[ebl_pkg::IR_W-1:1]};
                    ebl_pkg::T_UPD_IR: ir_q    <= ir_sh_q;
                    ebl_pkg::T_CAP_DR: dr_q    <= cap_val;
                    ebl_pkg::T_SH_DR:  dr_q    <= {tdi_q[1], dr_q[W-1:1]};
                    default: ;
                endcase
            end
            if (tck_fall) begin
                tdo_q    <= (tap_q == ebl_pkg::T_SH_IR) ? ir_sh_q[0] : dr_q[0];
                tdo_oe_q <= (tap_q == ebl_pkg::T_SH_IR) || (tap_q == ebl_pkg::T_SH_DR);
            end
        end
    end
    // ************************************************************
    // Security settings
    // ************************************************************
    // Nonvolatile in silicon; here sys_rst stands for a blank part
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_q  <= '0;
            pass_q <= '0;
            lock_q <= ebl_pkg::FLAG_RST;
            unlk_q <= ebl_pkg::FLAG_RST;
            perm_q <= ebl_pkg::FLAG_RST;
        end else if (upd_dr) begin
            case (ir_q)
                ebl_pkg::IR_KEY:    if (can_sec) key_q <= dr_q;
                ebl_pkg::IR_PASS: if (can_sec) begin
                    pass_q <= dr_q[PASS_W-1:0];
                    lock_q <= 1'b1;
                    unlk_q <= 1'b0;
                end
                ebl_pkg::IR_UNLOCK: unlk_q <= (dr_q[PASS_W-1:0] == pass_q);
                ebl_pkg::IR_PERM:   if (can_sec) perm_q <= 1'b1;
                default: ;
            endcase
        end
    end
    // ************************************************************
    // Stream buffer, decrypt and check
    // ************************************************************
    logic [W-1:0] f_data;
    logic         f_valid;
    logic         f_in_rdy;
    wire          word_evt = upd_dr && (ir_q == ebl_pkg::IR_STREAM);
    wire          f_ready  = (ld_q == ebl_pkg::L_IDLE);
    ebl_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (word_evt),
        .in_ready  (f_in_rdy),
        .in_data   (dr_q),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );
    logic [W-1:0]  buf_mem [STREAM_WORDS];
    logic [W-1:0]  prev_q;
    logic [W-1:0]  mac_q;
    logic [CW-1:0] cnt_q;
    logic          have_q;
    logic          endp_q;
    logic [AW-1:0] pa_q;
    logic          erase_q;
    logic          pv_q;
    logic [ebl_pkg::TGT_W-1:0] tgt_q;
    logic          stall_q;
    logic [W-1:0]  pd_q;
    wire           pop   = f_valid && f_ready;
    wire [W-1:0]   plain = f_data ^ keystream(key_q, cnt_q + CW'(have_q));
    wire [W-1:0]   hdr   = buf_mem[0];
    wire           magic_ok = hdr[ebl_pkg::MAGIC_LSB +: $bits(ebl_pkg::MAGIC)] == ebl_pkg::MAGIC;
    // Foreign key scrambles both header and tag, so this fails
    wire           check_ok = have_q && (cnt_q != '0) && !ovr_q && magic_ok
                              && (mac_q == prev_q) && can_mod;
    wire           last_pa  = (CW'(pa_q) + CW'(1) == cnt_q);
    always_ff @(posedge core_clk) begin
        if (pop && have_q && (cnt_q < CW'(STREAM_WORDS))) begin
            buf_mem[cnt_q[AW-1:0]] <= prev_q;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ld_q    <= ebl_pkg::L_IDLE;
            prev_q  <= '0;
            mac_q   <= '0;
            cnt_q   <= '0;
            have_q  <= ebl_pkg::FLAG_RST;
            endp_q  <= ebl_pkg::FLAG_RST;
            ovr_q   <= ebl_pkg::FLAG_RST;
            ok_q    <= ebl_pkg::FLAG_RST;
            fail_q  <= ebl_pkg::FLAG_RST;
            erase_q <= ebl_pkg::FLAG_RST;
            pv_q    <= ebl_pkg::FLAG_RST;
            pa_q    <= '0;
            tgt_q   <= '0;
            stall_q <= ebl_pkg::FLAG_RST;
            pd_q    <= '0;
        end else begin
            stall_q <= !f_in_rdy;
            case (ld_q)
                ebl_pkg::L_IDLE: begin
                    if (pop) begin
                        prev_q <= plain;
                        have_q <= 1'b1;
                        if (!have_q) begin
                            ok_q   <= 1'b0;
                            fail_q <= 1'b0;
                        end else if (cnt_q < CW'(STREAM_WORDS)) begin
                            mac_q <= mac_step(mac_q, prev_q, key_q);
                            cnt_q <= cnt_q + CW'(1);
                        end else begin
                            ovr_q <= 1'b1;
                        end
                    end else if (endp_q) begin
                        endp_q <= 1'b0;
                        ld_q   <= ebl_pkg::L_CHECK;
                    end
                end
                ebl_pkg::L_CHECK: begin
                    if (check_ok) begin
                        erase_q <= 1'b1;
                        tgt_q   <= hdr[ebl_pkg::TGT_LSB +: ebl_pkg::TGT_W];
                        pa_q    <= AW'(1);
                        pd_q    <= buf_mem[AW'(1)];
                        ld_q    <= ebl_pkg::L_ERASE;
                    end else begin
                        fail_q  <= 1'b1;
                        cnt_q   <= '0;
                        ld_q    <= ebl_pkg::L_IDLE;
                    end
                    have_q <= 1'b0;
                    mac_q  <= '0;
                    ovr_q  <= 1'b0;
                end
                ebl_pkg::L_ERASE: begin
                    if (arr_ack) begin
                        erase_q <= 1'b0;
                        pv_q    <= (cnt_q > CW'(1));
                        if (cnt_q == CW'(1)) begin
                            ok_q  <= 1'b1;
                            cnt_q <= '0;
                            ld_q  <= ebl_pkg::L_IDLE;
                        end else begin
                            ld_q  <= ebl_pkg::L_PROG;
                        end
                    end
                end
                ebl_pkg::L_PROG: begin
                    if (arr_ack) begin
                        if (last_pa) begin
                            pv_q  <= 1'b0;
                            ok_q  <= 1'b1;
                            cnt_q <= '0;
                            ld_q  <= ebl_pkg::L_IDLE;
                        end else begin
                            pa_q <= pa_q + AW'(1);
                            pd_q <= buf_mem[pa_q + AW'(1)];
                        end
                    end
                end
                default: ld_q <= ebl_pkg::L_IDLE;
            endcase
            // Set after the case so a same-cycle clear loses
            if (upd_ir && (ir_sh_q == ebl_pkg::IR_END)) endp_q <= 1'b1;
            if (word_evt && !f_in_rdy) ovr_q <= 1'b1;
        end
    end
    logic busy_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) busy_q <= ebl_pkg::FLAG_RST;
        else busy_q <= (ld_q == ebl_pkg::L_CHECK) && check_ok
                    || ((ld_q == ebl_pkg::L_ERASE) || (ld_q == ebl_pkg::L_PROG))
                       && !(arr_ack && (ld_q == ebl_pkg::L_PROG) && last_pa)
                       && !(arr_ack && (ld_q == ebl_pkg::L_ERASE) && cnt_q == CW'(1));
    end
    assign tdo          = tdo_q;
    assign tdo_oe       = tdo_oe_q;
    assign erase_req    = erase_q;
    assign erase_target = tgt_q;
    assign prog_valid   = pv_q;
    assign prog_addr    = pa_q;
    assign prog_data    = pd_q;
    assign auth_pass    = ok_q;
    assign auth_fail    = fail_q;
    assign cfg_busy     = busy_q;
    assign lock_active  = lock_q;
    assign perm_active  = perm_q;
    assign fifo_stall   = stall_q;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_fail_no_erase: assert property (ld_q == ebl_pkg::L_CHECK && !check_ok |=> !erase_q && fail_q)
        else $error("erase after failed check");
    a_erase_after_ok: assert property ($rose(erase_q) |-> $past(ld_q == ebl_pkg::L_CHECK && check_ok))
        else $error("erase without passing check");
    a_prog_after_erase: assert property ($rose(pv_q) |-> $past(erase_q && arr_ack))
        else $error("program before erase done");
    a_fail_quiet: assert property (fail_q |-> !erase_q && !pv_q && !busy_q)
        else $error("activity while failed");
    a_busy_commit: assert property (busy_q |-> erase_q || pv_q)
        else $error("user logic disturbed outside commit");
    a_lock_key: assert property (lock_q && !unlk_q |=> $stable(key_q) && $stable(pass_q))
        else $error("locked settings changed");
    a_perm_freeze: assert property (perm_q |=> perm_q && $stable(key_q) && $stable(pass_q))
        else $error("permanent settings changed");
    a_ir_update: assert property (upd_ir |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated");
    a_verdict: assert property (ld_q == ebl_pkg::L_CHECK |=> fail_q || erase_q)
        else $error("no verdict after check");
    c_pass: cover property ($rose(ok_q));
    c_fail: cover property ($rose(fail_q));
    c_perm: cover property ($rose(perm_q));
endmodule

//--- testbench/ebl_jtag_host.sv
// Purpose: Programmer model driving the test-access port pins
// Assumes: Port starts in Test-Logic-Reset, tck idles low
// Notes:   tdo is taken just before each tck rise
`timescale 1ns/1ps
module ebl_jtag_host (
    // Port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // ********
    // Pin sequencing
    // ********
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Idle tdi flips so a stale bit never passes for data
    task automatic step(input logic m, input logic b, output logic o);
        tms = m;
        tdi = b;
        #80;
        o = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] path, input int n);
        logic o;
        for (int i = 0; i < n; i++) step(path[i], ~tdi, o);
    endtask
    task automatic ir(input logic [3:0] code);
        logic o;
        walk(8'h03, 4);
        for (int i = 0; i < 4; i++) step(i == 3, code[i], o);
        walk(8'h01, 2);
    endtask
    task automatic dr(input logic [127:0] din, output logic [127:0] dout);
        walk(8'h01, 3);
        for (int i = 0; i < 128; i++) step(i == 127, din[i], dout[i]);
        walk(8'h01, 2);
    endtask
endmodule

//--- testbench/ebl_loader_test.sv
// Purpose: Self-checking bench for the encrypted stream loader
// Assumes: Array side acknowledges each request one cycle later
// Notes:   Streams are built here from the cipher and check equations
`timescale 1ns/1ps
module ebl_loader_test;
    // ********
    // Signals
    // ********
    localparam int           N  = 16;
    localparam logic [127:0] KA = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
    localparam logic [127:0] KB = 128'hfeed_0000_1111_2222_3333_4444_5555_6666;
    localparam logic [127:0] PK = 128'hc0de_7a11;
    logic         core_clk, sys_rst, arr_ack;
    wire logic    tck, tms, tdi, tdo, tdo_oe, erase_req, prog_valid;
    wire logic    auth_pass, auth_fail, cfg_busy, lock_active, perm_active;
    wire logic    fifo_stall;
    wire logic [ebl_pkg::TGT_W-1:0] erase_target;
    wire logic [3:0]   prog_addr;
    wire logic [127:0] prog_data;
    logic [127:0] d;
    logic [127:0] exp_p [N+2];
    logic [2:0]   exp_tgt;
    int           err_total = 0, total_checks = 0, n_erase, n_prog;
    ebl_loader #(.STREAM_WORDS(N)) DUT (.core_clk, .sys_rst, .tck, .tms, .tdi,
        .tdo, .tdo_oe, .arr_ack, .erase_req, .erase_target, .prog_valid,
        .prog_addr, .prog_data, .auth_pass, .auth_fail, .cfg_busy,
        .lock_active, .perm_active, .fifo_stall);
    ebl_jtag_host host (.tck, .tms, .tdi, .tdo);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Array side: one-cycle ack pulse, so no word is acked twice
    always @(posedge core_clk) begin
        arr_ack <= #1 (erase_req | prog_valid) & ~arr_ack;
        if (arr_ack && erase_req) begin
            n_erase++;
            check(erase_target, exp_tgt);
            check(cfg_busy, 1'b1);
        end
        if (arr_ack && prog_valid) begin
            n_prog++;
            check(n_erase, 1);
            check(prog_addr, n_prog);
            check(prog_data, exp_p[prog_addr]);
        end
    end
    task automatic send(input logic [127:0] k, input logic [2:0] tgt, input int nd,
                        input logic ok);
        logic [127:0] p, mac;
        mac = '0;
        exp_tgt = tgt;
        n_erase = 0;
        n_prog = 0;
        host.ir(ebl_pkg::IR_STREAM);
        for (int i = 0; i <= nd + 1; i++) begin
            p = (i == 0) ? {ebl_pkg::MAGIC, 109'h0, tgt} : {4{32'(i) ^ 32'h5a5a_0000}};
            if (i > nd) p = mac;
            else begin
                exp_p[i] = p;
                mac = {mac[126:0], mac[127]} ^ p ^ k;
            end
            host.dr(p ^ k ^ {16{8'(i)}}, d);
            if (i == 0) check(auth_pass | auth_fail, 1'b0);
            check({erase_req, cfg_busy, fifo_stall}, 3'h0);
        end
        host.ir(ebl_pkg::IR_END);
        repeat (500) if (auth_pass === auth_fail) @(negedge core_clk);
        check(auth_pass, ok);
        check(auth_fail, !ok);
        check(n_erase, ok);
        check(n_prog, ok ? nd : 0);
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        check({tdo_oe, erase_req, prog_valid, auth_pass, lock_active, perm_active}, 6'h0);
        host.walk(8'h00, 1);
        host.ir(ebl_pkg::IR_KEY);
        host.dr(KA, d);
        send(KA, 3'b101, 2, 1'b1);
        host.ir(ebl_pkg::IR_STATUS);
        host.dr(128'h0, d);
        check(d[5:0], 6'h01);
        send(KB, 3'b001, 1, 1'b0);
        send(KA, 3'b010, N, 1'b0);
        host.ir(ebl_pkg::IR_PASS);
        host.dr(PK, d);
        check(lock_active, 1'b1);
        send(KA, 3'b111, 1, 1'b0);
        host.ir(ebl_pkg::IR_KEY);
        host.dr(KB, d);
        host.ir(ebl_pkg::IR_UNLOCK);
        host.dr(PK, d);
        send(KA, 3'b011, 0, 1'b1);
        host.ir(ebl_pkg::IR_PERM);
        host.dr(128'h0, d);
        check(perm_active, 1'b1);
        host.ir(ebl_pkg::IR_KEY);
        host.dr(KB, d);
        send(KA, 3'b100, 1, 1'b1);
        host.ir(ebl_pkg::IR_STATUS);
        host.dr(128'h0, d);
        check(d[4:0], 5'h1d);
        wrap_up;
    end
    // Whole run is about 50k cycles; stop well past that
    initial begin
        #2_000_000;
        err_total++;
        wrap_up;
    end
endmodule
